/* design/sar_adc_sequencer.sv */
// apb slave and phase sequencer of an 8-bit successive-approximation converter
// assumes an analog comparator outside, answering compare_high for the trial code within one enable period
`timescale 1ns/10ps
`include "sar_adc_defines.svh"

module sar_adc_sequencer #(
  parameter int unsigned CHANNELS = `CH_COUNT,
  parameter bit HAS_UPPER_GROUP = 1'b1,
  parameter int unsigned STABLE_PERIODS = `STABLE_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic compare_high,
  input wire logic [CHANNELS-1:0] pin_level,
  output logic [CHANNELS-1:0] pin_digital,
  output logic [CHANNELS-1:0] channel_enable,
  output logic converter_powered,
  output logic sample_connect,
  output sar_adc_pkg::sample_t trial_code,
  output logic adc_clk_en,
  output logic irq
);
  import sar_adc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic conversion_done_flag_q;
  logic converter_on_q;
  chan_t channel_select_q;
  sample_t conversion_result_q;
  phase_t phase_q, phase_d;
  logic [1:0] div_q;
  logic [3:0] period_q;
  logic [7:0] stable_q;
  sample_t sar_q;
  logic [31:0] prdata_q;

  wire access = psel && penable;
  wire hit_result = (paddr == `RESULT_ADDR);
  wire hit_ctrl = (paddr == `CTRL_ADDR);
  wire ctrl_write = access && pwrite && hit_ctrl && pstrb[0];
  wire result_read = access && !pwrite && hit_result;
  // only the low byte lane carries register bits
  wire [7:0] wdata = pwdata[7:0];
  wire wr_on = wdata[`ON_BIT];
  // small packages tie the msb low so the upper group never wakes
  wire [3:0] wr_chan = HAS_UPPER_GROUP ? wdata[`CH_MSB:`CH_LSB] : {1'b0, wdata[`CH_MSB-1:`CH_LSB]};
  wire [7:0] ctrl_view = {conversion_done_flag_q, 1'b0, converter_on_q, 1'b0, channel_select_q};

  assign pready = 1'b1;
  assign pslverr = access && !(hit_result || hit_ctrl || (pwrite && hit_result && 1'b0));
  assign prdata = prdata_q;
  assign irq = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock enable and phase sequencer

  // sequencer runs only while on and not halted; wait mode is ignored on purpose
  wire run = converter_on_q && !halt_mode;
  wire tick = (div_q == 2'(`CLK_DIV - 1));
  wire restart = ctrl_write && wr_on;
  wire last_period = (period_q == 4'(`CONV_PERIODS - 1));
  wire conv_end = run && tick && (phase_q == PH_APPROX) && last_period && !restart;
  wire [2:0] step = 3'(period_q - 4'(`LOAD_PERIODS));
  wire sample_t bit_mask = 8'h80 >> step;
  wire sample_t sar_next = compare_high ? sar_q : (sar_q & ~bit_mask);

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_OFF: if (run) phase_d = PH_STABLE;
      PH_STABLE: if (tick && stable_q == 8'(STABLE_PERIODS - 1)) phase_d = PH_LOAD;
      PH_LOAD: if (tick && period_q == 4'(`LOAD_PERIODS - 1)) phase_d = PH_APPROX;
      PH_APPROX: if (tick && last_period) phase_d = PH_LOAD;
      default: phase_d = PH_OFF;
    endcase
    if (!run) phase_d = PH_OFF;
    else if (restart && phase_q != PH_OFF && phase_q != PH_STABLE) phase_d = PH_LOAD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_OFF;
      div_q <= 2'h0;
      period_q <= 4'h0;
      stable_q <= 8'h00;
      sar_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      // divider parked while off so no stray tick lands on the power-up cycle
      div_q <= (phase_d == PH_OFF || phase_d != phase_q || restart) ? 2'h0 : div_q + 2'h1;
      if (phase_d == PH_STABLE && tick) stable_q <= stable_q + 8'h01;
      else if (phase_d != PH_STABLE) stable_q <= 8'h00;
      if (phase_d == PH_OFF || phase_d == PH_STABLE || restart) period_q <= 4'h0;
      else if (tick) period_q <= last_period ? 4'h0 : period_q + 4'h1;
      if (phase_d == PH_LOAD) sar_q <= 8'h80;
      else if (phase_q == PH_APPROX && tick) sar_q <= last_period ? 8'h80 : (sar_next | (bit_mask >> 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_q <= 1'b0;
      channel_select_q <= 4'h0;
    end else if (ctrl_write) begin
      converter_on_q <= wr_on;
      channel_select_q <= wr_chan;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag_q <= 1'b0;
      conversion_result_q <= `RESULT_RESET;
    end else begin
      if (conv_end) begin
        conversion_done_flag_q <= 1'b1;
        conversion_result_q <= sar_next;
      end else if (ctrl_write || result_read) begin
        conversion_done_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_q <= {24'h000000, (paddr == `RESULT_ADDR) ? conversion_result_q :
                                                          (paddr == `CTRL_ADDR) ? ctrl_view : 8'h00};
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog front end controls

  assign converter_powered = (phase_q != PH_OFF);
  assign sample_connect = (phase_q == PH_LOAD);
  assign trial_code = sar_q;
  assign adc_clk_en = run && tick && (phase_q != PH_OFF);
  assign pin_digital = pin_level;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign channel_enable[g] = converter_powered && (channel_select_q == 4'(g));
    end
  endgenerate

  wire unused_ok = wait_mode ^ (^pwdata[31:8]) ^ (^pstrb[3:1]);
endmodule

/* design/sar_adc_defines.svh */
// register offsets, field positions, reset values and timing counts of the converter sequencer
// assumes inclusion by the design module only
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
// printed offsets are indexes; byte address is four times the index
`define RESULT_IDX 4'ha
`define CTRL_IDX 4'hb
`define RESULT_ADDR 12'h028
`define CTRL_ADDR 12'h02c
`define DONE_BIT 7
`define ON_BIT 5
`define CH_LSB 0
`define CH_MSB 3
`define RESULT_RESET 8'h00
`define CTRL_RESET 8'h00
`define CLK_DIV 4
`define CONV_PERIODS 12
`define LOAD_PERIODS 4
`define SAR_STEPS 8
`define CH_COUNT 12
`define STABLE_PERIODS 16
`endif

/* design/sar_adc_pkg.sv */
// types shared by the converter sequencer and its bench
// assumes the defines header sits beside it
package sar_adc_pkg;
  typedef enum logic [1:0] {
    PH_OFF,
    PH_STABLE,
    PH_LOAD,
    PH_APPROX
  } phase_t;
  typedef logic [7:0] sample_t;
  typedef logic [3:0] chan_t;
endpackage

/* sim/sar_adc_props.sv */
// port checker of the converter sequencer
// assumes a bind onto sar_adc_sequencer with twelve channels
`timescale 1ns/10ps
module sar_adc_props (
  input wire logic pclk, presetn, psel, penable, pwrite, halt_mode,
  input wire logic [11:0] paddr, pin_level, pin_digital, channel_enable,
  input wire logic [31:0] prdata,
  input wire logic pready, pslverr, converter_powered, sample_connect, adc_clk_en, irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  ////////////////////////////////////////////////////////////
  no_irq_a: assert property (!irq) else $error("irq raised");
  pin_copy_a: assert property (pin_digital == pin_level) else $error("digital read lost");
  zero_wait_a: assert property (acc |-> pready) else $error("wait state");
  tick_gap_a: assert property (adc_clk_en |=> !adc_clk_en [*3]) else $error("tick spacing");
  load_power_a: assert property (sample_connect |-> converter_powered) else $error("load while off");
  one_chan_a: assert property (converter_powered |-> $onehot0(channel_enable)) else $error("two inputs");
  off_quiet_a: assert property (!converter_powered |-> !channel_enable && !adc_clk_en) else $error("off busy");
  halt_off_a: assert property (halt_mode [*2] |-> !converter_powered) else $error("halt ignored");
  rsvd_zero_a: assert property (acc && !pwrite && paddr == 12'h02c |-> !prdata[6] && !prdata[4])
    else $error("reserved bit set");
  bad_addr_a: assert property (acc && paddr != 12'h02c && paddr != 12'h028 |-> pslverr) else $error("no error");
  cover property ($rose(sample_connect));
  cover property (acc && pslverr);
  cover property ($fell(converter_powered));
endmodule

/* sim/analog_front_model.sv */
// sample capacitor and comparator facing the sequencer
// assumes one-hot enables and one level per input from the bench
`timescale 1ns/10ps
module analog_front_model (
  input wire logic [11:0] channel_enable,
  input wire logic sample_connect,
  input wire sar_adc_pkg::sample_t trial_code,
  input wire logic [95:0] analog_input_voltage,
  output logic compare_high
);
  logic [7:0] held = 8'h00;
  // capacitor keeps its charge once isolated
  always @* for (int i = 0; i < 12; i++) if (sample_connect && channel_enable[i]) held = analog_input_voltage[8*i +: 8];
  assign compare_high = held >= trial_code;
endmodule

/* sim/tb_top.sv */
// self-checking bench of the converter sequencer
// assumes the design, its package and the analog model compiled first
`timescale 1ns/10ps
module tb_top;
  import sar_adc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wait_mode = 0, halt_mode = 0, err;
  logic [11:0] paddr = 12'h000, pin_level = 12'h000, pin_digital, channel_enable;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, compare_high, converter_powered, sample_connect, adc_clk_en, irq;
  logic [95:0] analog_input_voltage = 96'h0;
  sample_t trial_code, v;
  chan_t ch;
  int mismatches = 0, samples_checked = 0, n;
  initial forever #10 pclk = ~pclk;
  sar_adc_sequencer #(.STABLE_PERIODS(1)) sar_adc_sequencer_inst (.*);
  analog_front_model analog_front_model_inst (.*);
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 50) begin mismatches++; print_verdict(); end
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100; i++) begin apb(0, 12'h02c, 0); if (rd[7] === 1'b1) return; end
    mismatches++;
    print_verdict();
  endtask
  task automatic span(input logic lvl);
    for (n = 0; n < 200 && sample_connect === lvl; n++) @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'hd4098873);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h028, 0); chk("result reset", 0, rd);
    apb(0, 12'h02c, 0); chk("ctrl reset", 0, rd);
    apb(0, 12'h100, 0); chk("unmapped", 1, err);
    for (int t = 0; t < 4; t++) begin
      ch = (t == 0) ? 4'd11 : 4'($urandom_range(0, 10));
      analog_input_voltage <= (t == 0) ? '1 : (t == 1) ? '0 : {$urandom, $urandom, $urandom};
      wait_mode <= t[0]; pin_level <= 12'($urandom);
      apb(1, 12'h02c, {4'h0, ch});
      apb(1, 12'h02c, {4'h2, ch});
      wait_done();
      v = analog_input_voltage[8*ch +: 8];
      apb(0, 12'h028, 0); chk("result", v, rd);
      apb(0, 12'h02c, 0); chk("ctrl after read", {4'h2, ch}, rd);
      apb(1, 12'h028, 8'h5a); apb(0, 12'h028, 0); chk("result ro", v, rd);
      $display("channel %0d test ended", ch);
    end
    span(1); span(0); span(1); chk("load span", 16, n);
    span(0); chk("approx span", 32, n);
    wait_done();
    apb(1, 12'h02c, {4'h2, ch}); @(negedge pclk); chk("restart", 1, sample_connect);
    apb(0, 12'h02c, 0); chk("done cleared", {4'h2, ch}, rd);
    apb(1, 12'h02c, {4'h0, ch}); repeat (2) @(negedge pclk); chk("off", 0, converter_powered);
    apb(0, 12'h028, 0); chk("result kept", v, rd);
    apb(1, 12'h02c, {4'h2, ch}); halt_mode <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("halt", 0, converter_powered);
    @(posedge pclk);
    halt_mode <= 1'b0;
    wait_done(); apb(0, 12'h028, 0); chk("after halt", v, rd);
    $display("timing and mode tests ended");
    print_verdict();
  end
  initial begin
    #1900000;
    mismatches++;
    print_verdict();
  end
endmodule
bind sar_adc_sequencer sar_adc_props sar_adc_props_inst (.*);
